/* File: verilog/wcca_dev.sv */
// Device end: write CRC check, error flags and alert pulse
`timescale 1ns/1ps
`default_nettype none
module wcca_dev (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  resetn,
  // Link to controller
  wcca_link_if.dev   link,
  // Device configuration and events
  input  wire logic  x16_en,
  input  wire logic  ca_parity_err,
  // Array write port
  output logic        arr_we,
  output logic [63:0] arr_data,
  output logic [7:0]  arr_dm_n
);

  // Mode state
  logic        crc_en_q;
  logic        dm_en_q;
  logic        wdbi_en_q;
  logic        err_q;
  logic        log_q;

  // Captured burst
  logic        cap_valid_q;
  logic        cap_a2_q;
  logic [63:0] cap_dq_q;
  logic [7:0]  cap_dm_q;
  logic [15:0] cap_crc_q;

  // Check and alert
  logic [1:0]             lane_bad;
  logic                   bad;
  logic                   mism_q;
  logic                   we_q;
  logic [63:0]            data_q;
  logic [7:0]             dm_q;
  logic [wcca_pkg::ALERT_CNT_W-1:0] cnt_q;
  logic [wcca_pkg::ALERT_CNT_W-1:0] cnt_d;
  logic                   oe_q;
  logic                   mr5_wr;
  logic                   mr2_wr;

  assign mr5_wr = link.mrs_valid && (link.mrs_addr == wcca_pkg::MR5_ADDR);
  assign mr2_wr = link.mrs_valid && (link.mrs_addr == wcca_pkg::MR2_ADDR);

  // Write CRC enable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      crc_en_q <= wcca_pkg::MR_RESET[wcca_pkg::MR2_CRC_EN_BIT];
    end else if (mr2_wr) begin
      crc_en_q <= link.mrs_data[wcca_pkg::MR2_CRC_EN_BIT];
    end
  end

  // Mask and inversion enables
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dm_en_q   <= wcca_pkg::MR_RESET[wcca_pkg::MR5_DM_BIT];
      wdbi_en_q <= wcca_pkg::MR_RESET[wcca_pkg::MR5_WDBI_BIT];
    end else if (mr5_wr) begin
      dm_en_q   <= link.mrs_data[wcca_pkg::MR5_DM_BIT];
      wdbi_en_q <= link.mrs_data[wcca_pkg::MR5_WDBI_BIT];
    end
  end

  // Burst capture
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cap_valid_q <= 1'b0;
      cap_a2_q    <= 1'b0;
      cap_dq_q    <= 64'h0;
      cap_dm_q    <= 8'hff;
      cap_crc_q   <= 16'h0;
    end else begin
      cap_valid_q <= link.wr_valid;
      if (link.wr_valid) begin
        cap_a2_q  <= link.wr_a2;
        cap_dq_q  <= link.wr_dq;
        cap_dm_q  <= link.wr_dm_n;
        cap_crc_q <= link.wr_crc;
      end
    end
  end

  // One tree per byte lane
  genvar l;
  generate
    for (l = 0; l < 2; l++) begin : g_lane
      logic [7:0] calc;
      assign calc        = wcca_pkg::wcca_crc8(wcca_pkg::wcca_tree(cap_dq_q, cap_dm_q, l, cap_a2_q,
                                                                   dm_en_q | wdbi_en_q));
      assign lane_bad[l] = (calc != cap_crc_q[l*8+:8]) && ((l == 0) || x16_en);
    end
  endgenerate

  assign bad = cap_valid_q && crc_en_q && (|lane_bad);

  // Compare result
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mism_q <= 1'b0;
    end else begin
      mism_q <= bad;
    end
  end

  // Array commit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      we_q   <= 1'b0;
      data_q <= 64'h0;
      dm_q   <= 8'hff;
    end else begin
      we_q <= cap_valid_q && !(bad && dm_en_q);
      if (cap_valid_q) begin
        data_q <= cap_dq_q;
        dm_q   <= dm_en_q ? cap_dm_q : 8'hff;
      end
    end
  end

  // Error status bit, set wins over clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      err_q <= wcca_pkg::MR_RESET[wcca_pkg::MR5_ERR_BIT];
    end else if (mism_q) begin
      err_q <= 1'b1;
    end else if (mr5_wr) begin
      err_q <= link.mrs_data[wcca_pkg::MR5_ERR_BIT];
    end
  end

  // Error log flag set by mismatch, cleared with status bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      log_q <= 1'b0;
    end else if (mism_q) begin
      log_q <= 1'b1;
    end else if (mr5_wr && !link.mrs_data[wcca_pkg::MR5_ERR_BIT]) begin
      log_q <= 1'b0;
    end
  end

  // Alert length: parity long, CRC short
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_d != '0) begin
      cnt_d = cnt_d - 1'b1;
    end
    if (ca_parity_err) begin
      cnt_d = wcca_pkg::ALERT_CNT_W'(wcca_pkg::PARITY_ALERT_CYC);
    end else if (mism_q && (cnt_d < wcca_pkg::ALERT_CNT_W'(wcca_pkg::CRC_ALERT_CYC))) begin
      cnt_d = wcca_pkg::ALERT_CNT_W'(wcca_pkg::CRC_ALERT_CYC);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Driver on while counting, released after
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (cnt_d != '0);
    end
  end

  assign link.dev_alert_o  = 1'b0;
  assign link.dev_alert_oe = oe_q;
  assign link.err_status   = err_q;
  assign link.err_log      = log_q;
  assign arr_we            = we_q;
  assign arr_data          = data_q;
  assign arr_dm_n          = dm_q;

endmodule : wcca_dev
`default_nettype wire

/* File: include/wcca_pkg.sv */
// Constants and CRC tree helpers shared by both ends of the write CRC link
// Overview of operation
// - A2 set feeds upper nibble into tree
// - Lower mask bits used, else forced one
// - Upper mask bits used, else forced one
// - A2 clear: fixed XOR tree, padding ones
// - A2 set: same tree, shifted data
// - CRC errors share the parity alert line
// - CRC alert is a short low pulse
// - Controller tells errors apart by width
// - Controller tolerates longer chained alert pulses
// - Mismatch sets mode register error bit
// - Mismatch also sets log flag
// - Both stay set until cleared by MRS
// - Controller reissues writes after CRC error
// - Controller keeps last write burst for replay
// - Signalling starts the clock after compare
// - Pulse spans drive low until release
// - Tree takes 36 data bits, CRC ninth
// - Two independent trees on x16 devices
// - Masking on: failed write is discarded
// - Masking off: failed write still committed
`default_nettype none
package wcca_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned CRC_ALERT_NS     = 60;
  localparam int unsigned CRC_ALERT_CYC    = (CRC_ALERT_NS * CLK_MHZ) / 1000;
  localparam int unsigned PARITY_ALERT_CYC = 48;
  localparam int unsigned PARITY_MIN_CYC   = 45;
  localparam int unsigned ALERT_CNT_W      = 6;
  localparam int unsigned NIB_OFS          = 4;
  localparam int unsigned DM_BASE          = 64;
  // Mode register addresses, bits and reset value
  localparam logic [2:0]  MR2_ADDR         = 3'h2;
  localparam logic [2:0]  MR5_ADDR         = 3'h5;
  localparam int unsigned MR2_CRC_EN_BIT   = 12;
  localparam int unsigned MR5_ERR_BIT      = 3;
  localparam int unsigned MR5_DM_BIT       = 10;
  localparam int unsigned MR5_WDBI_BIT     = 11;
  localparam int unsigned MPR3_CRC_BIT     = 7;
  localparam logic [12:0] MR_RESET         = 13'h0000;
  // Controller register map
  localparam logic [7:0]  REG_WDATA0       = 8'h00;
  localparam logic [7:0]  REG_WDATA1       = 8'h04;
  localparam logic [7:0]  REG_WCTRL        = 8'h08;
  localparam logic [7:0]  REG_MRS          = 8'h0c;
  localparam logic [7:0]  REG_STATUS       = 8'h10;
  localparam int unsigned WCTRL_A2_BIT     = 8;
  localparam int unsigned WCTRL_REPLAY_BIT = 29;
  localparam int unsigned WCTRL_FLIP_BIT   = 30;
  localparam int unsigned WCTRL_GO_BIT     = 31;
  localparam int unsigned MRS_DATA_LSB     = 16;

  // Builds the 72 tree inputs of one byte lane
  function automatic logic [71:0] wcca_tree(input logic [63:0] dq, input logic [7:0] dm_n,
                                            input int lane, input logic a2, input logic dm_use);
    logic [71:0] d;
    logic [71:0] t;
    int          ofs;
    d   = '1;
    t   = '1;
    ofs = a2 ? NIB_OFS : 0;
    for (int b = 0; b < 4; b++) begin
      for (int j = 0; j < 8; j++) begin
        d[j*8+b+ofs] = dq[b*16+lane*8+j];
      end
      if (dm_use) begin
        d[DM_BASE+b+ofs] = dm_n[b*2+lane];
      end
    end
    // Upper nibble positions take the lower nibble slots
    for (int s = 0; s < 9; s++) begin
      for (int b = 0; b < 4; b++) begin
        t[s*8+b] = d[s*8+b+ofs];
      end
    end
    return t;
  endfunction : wcca_tree

  // Serial CRC-8 (x^8+x^2+x+1), highest input first
  function automatic logic [7:0] wcca_crc8(input logic [71:0] t);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      fb = c[7] ^ t[i];
      c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : wcca_crc8
endpackage : wcca_pkg
`default_nettype wire

/* File: include/wcca_link_if.sv */
// Link between controller and device: write bursts, mode sets, shared alert
`timescale 1ns/1ps
`default_nettype none
interface wcca_link_if;
  logic        wr_valid;
  logic        wr_a2;
  logic [63:0] wr_dq;
  logic [7:0]  wr_dm_n;
  logic [15:0] wr_crc;
  logic        mrs_valid;
  logic [2:0]  mrs_addr;
  logic [12:0] mrs_data;
  logic        dev_alert_o;
  logic        dev_alert_oe;
  logic        err_status;
  logic        err_log;
  logic        alert_n;

  // Open-drain line with pull-up
  assign alert_n = dev_alert_oe ? dev_alert_o : 1'b1;

  modport dev (input wr_valid, wr_a2, wr_dq, wr_dm_n, wr_crc, mrs_valid, mrs_addr, mrs_data,
               output dev_alert_o, dev_alert_oe, err_status, err_log);
  modport ctrl (output wr_valid, wr_a2, wr_dq, wr_dm_n, wr_crc, mrs_valid, mrs_addr, mrs_data,
                input alert_n, err_status, err_log);
endinterface : wcca_link_if
`default_nettype wire

/* File: verilog/wcca_ctrl.sv */
// Controller end: APB registers, burst send with CRC, alert width measure, replay
`timescale 1ns/1ps
`default_nettype none
module wcca_ctrl (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to device
  wcca_link_if.ctrl        link
);

  logic [31:0] wd0_q, wd1_q;
  logic        replay_q, dm_use_q;
  logic        rdy_q, err_q;
  logic [31:0] rd_q;
  logic        wv_q, a2_q, mv_q;
  logic [7:0]  dm_q;
  logic [63:0] dq_q;
  logic [15:0] crc_q, good_q;
  logic [2:0]  ma_q;
  logic [12:0] md_q;
  logic        s1_q, s2_q, s3_q;
  logic [7:0]  low_q, width_q, crcn_q, parn_q;
  logic        acc, wr, mapped, go, rise, crc_evt;
  logic [63:0] new_dq;
  logic [15:0] new_crc;

  assign acc    = psel && penable && rdy_q;
  assign wr     = acc && pwrite;
  assign mapped = (paddr == wcca_pkg::REG_WDATA0) || (paddr == wcca_pkg::REG_WDATA1) ||
                  (paddr == wcca_pkg::REG_WCTRL) || (paddr == wcca_pkg::REG_MRS) ||
                  (paddr == wcca_pkg::REG_STATUS);
  assign go     = wr && (paddr == wcca_pkg::REG_WCTRL) && pwdata[wcca_pkg::WCTRL_GO_BIT];
  assign new_dq = {wd1_q, wd0_q};
  assign new_crc = {wcca_pkg::wcca_crc8(wcca_pkg::wcca_tree(new_dq, pwdata[7:0], 1,
                      pwdata[wcca_pkg::WCTRL_A2_BIT], dm_use_q)),
                    wcca_pkg::wcca_crc8(wcca_pkg::wcca_tree(new_dq, pwdata[7:0], 0,
                      pwdata[wcca_pkg::WCTRL_A2_BIT], dm_use_q))};
  assign rise    = s2_q && !s3_q;
  assign crc_evt = rise && (low_q <= 8'(wcca_pkg::PARITY_MIN_CYC));

  // APB handshake, one wait state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rd_q  <= 32'h0;
    end else begin
      rdy_q <= psel && penable && !rdy_q;
      err_q <= psel && penable && !rdy_q && !mapped;
      case (paddr)
        wcca_pkg::REG_WDATA0: rd_q <= wd0_q;
        wcca_pkg::REG_WDATA1: rd_q <= wd1_q;
        wcca_pkg::REG_STATUS: rd_q <= {5'h0, s2_q, link.err_log, link.err_status, parn_q, crcn_q, width_q};
        default:              rd_q <= 32'h0;
      endcase
    end
  end

  // Software registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wd0_q    <= 32'h0;
      wd1_q    <= 32'h0;
      replay_q <= 1'b0;
      dm_use_q <= 1'b0;
    end else if (wr) begin
      if (paddr == wcca_pkg::REG_WDATA0) wd0_q <= pwdata;
      if (paddr == wcca_pkg::REG_WDATA1) wd1_q <= pwdata;
      if (paddr == wcca_pkg::REG_WCTRL) replay_q <= pwdata[wcca_pkg::WCTRL_REPLAY_BIT];
      if ((paddr == wcca_pkg::REG_MRS) && (pwdata[2:0] == wcca_pkg::MR5_ADDR)) begin
        dm_use_q <= pwdata[wcca_pkg::MRS_DATA_LSB+wcca_pkg::MR5_DM_BIT] |
                    pwdata[wcca_pkg::MRS_DATA_LSB+wcca_pkg::MR5_WDBI_BIT];
      end
    end
  end

  // Burst send; last burst kept for replay
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wv_q   <= 1'b0;
      a2_q   <= 1'b0;
      dm_q   <= 8'hff;
      dq_q   <= 64'h0;
      crc_q  <= 16'h0;
      good_q <= 16'h0;
    end else begin
      wv_q <= go || (crc_evt && replay_q);
      if (go) begin
        a2_q   <= pwdata[wcca_pkg::WCTRL_A2_BIT];
        dm_q   <= pwdata[7:0];
        dq_q   <= new_dq;
        good_q <= new_crc;
        crc_q  <= new_crc ^ {15'h0, pwdata[wcca_pkg::WCTRL_FLIP_BIT]};
      end else if (crc_evt && replay_q) begin
        crc_q  <= good_q;
      end
    end
  end

  // Mode register set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mv_q <= 1'b0;
      ma_q <= 3'h0;
      md_q <= 13'h0;
    end else begin
      mv_q <= wr && (paddr == wcca_pkg::REG_MRS);
      if (wr && (paddr == wcca_pkg::REG_MRS)) begin
        ma_q <= pwdata[2:0];
        md_q <= pwdata[wcca_pkg::MRS_DATA_LSB+:13];
      end
    end
  end

  // Alert width measure and classify
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      low_q   <= 8'h0;
      width_q <= 8'h0;
      crcn_q  <= 8'h0;
      parn_q  <= 8'h0;
    end else begin
      s1_q <= link.alert_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (!s2_q) begin
        low_q <= (low_q == 8'hff) ? low_q : low_q + 8'h01;
      end else begin
        low_q <= 8'h0;
      end
      if (rise) begin
        width_q <= low_q;
        if (crc_evt) crcn_q <= crcn_q + 8'h01;
        else parn_q <= parn_q + 8'h01;
      end
    end
  end

  assign prdata         = rd_q;
  assign pready         = rdy_q;
  assign pslverr        = err_q;
  assign link.wr_valid  = wv_q;
  assign link.wr_a2     = a2_q;
  assign link.wr_dq     = dq_q;
  assign link.wr_dm_n   = dm_q;
  assign link.wr_crc    = crc_q;
  assign link.mrs_valid = mv_q;
  assign link.mrs_addr  = ma_q;
  assign link.mrs_data  = md_q;

endmodule : wcca_ctrl
`default_nettype wire

/* File: tb/wcca_checker.sv */
// Assertions on the link between the controller and device ends
`timescale 1ns/1ps
`default_nettype none
module wcca_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Link signals
  input wire logic        wr_valid,
  input wire logic        mrs_valid,
  input wire logic [2:0]  mrs_addr,
  input wire logic [12:0] mrs_data,
  input wire logic        dev_alert_o,
  input wire logic        dev_alert_oe,
  input wire logic        err_status,
  input wire logic        err_log
);
  localparam int MAX_LOW = 54;
  logic [7:0] low_q;
  logic       clr;

  assign clr = mrs_valid && (mrs_addr == wcca_pkg::MR5_ADDR) && !mrs_data[wcca_pkg::MR5_ERR_BIT];

  // Length of the current alert drive
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_q <= 8'h00;
    end else begin
      low_q <= dev_alert_oe ? low_q + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_crc_start;
    $rose(err_log) && $rose(dev_alert_oe);
  endsequence
  sequence s_short_pulse;
    dev_alert_oe [*6] ##1 !dev_alert_oe;
  endsequence

  chk_drive_low:
    assert property (dev_alert_oe |-> !dev_alert_o) else $error("alert driver not low");
  chk_min_width:
    assert property ($rose(dev_alert_oe) |-> dev_alert_oe [*6]) else $error("alert pulse too short");
  chk_max_width:
    assert property (low_q <= MAX_LOW) else $error("alert pulse too long");
  chk_crc_width:
    assert property (s_crc_start |-> s_short_pulse) else $error("crc alert width wrong");
  chk_log_status:
    assert property ($rose(err_log) |-> err_status) else $error("log set without status");
  chk_err_write:
    assert property ($rose(err_log) |-> $past(wr_valid, 2) || $past(wr_valid, 3) || $past(wr_valid, 4))
      else $error("error flag without burst");
  chk_log_sticky:
    assert property ($fell(err_log) |-> $past(clr, 1) || $past(clr, 2)) else $error("log cleared early");
  chk_status_sticky:
    assert property ($fell(err_status) |-> $past(clr, 1) || $past(clr, 2)) else $error("status cleared early");
endmodule : wcca_checker
`default_nettype wire

/* File: tb/test_write_crc_check_and_alert.sv */
// Bench joining controller and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module test_write_crc_check_and_alert;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        x16_en = 1'b1;
  logic        ca_parity_err = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        arr_we;
  logic [63:0] arr_data;
  logic [7:0]  arr_dm_n;
  logic [15:0] cap_crc;
  logic [63:0] cap_arr;
  logic [7:0]  cap_dm;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n_wv = 0;
  int          n_we = 0;
  int          n_pl = 0;
  int          low = 0;
  int          last_low = 0;

  wcca_link_if lk ();
  wcca_dev u_wcca_dev (.clock(clock), .resetn(resetn), .link(lk), .x16_en(x16_en),
    .ca_parity_err(ca_parity_err), .arr_we(arr_we), .arr_data(arr_data), .arr_dm_n(arr_dm_n));
  wcca_ctrl u_wcca_ctrl (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
  wcca_checker u_chk (.clock(clock), .resetn(resetn), .wr_valid(lk.wr_valid), .mrs_valid(lk.mrs_valid),
    .mrs_addr(lk.mrs_addr), .mrs_data(lk.mrs_data), .dev_alert_o(lk.dev_alert_o),
    .dev_alert_oe(lk.dev_alert_oe), .err_status(lk.err_status), .err_log(lk.err_log));

  always #5 clock = ~clock;

  // Counts sends, commits and alert pulses
  always @(posedge clock) begin
    if (lk.wr_valid === 1'b1) begin
      n_wv++;
      cap_crc = lk.wr_crc;
    end
    if (arr_we === 1'b1) begin
      n_we++;
      cap_arr = arr_data;
      cap_dm = arr_dm_n;
    end
    if (lk.alert_n === 1'b0) begin
      low++;
    end else if (low != 0) begin
      last_low = low;
      low = 0;
      n_pl++;
    end
  end

  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Tree slots that enter check bit 0
  localparam logic [71:0] CRC0_TERMS = 72'h3d9177298cd0ad51c1;

  // Slot pin*8+beat for either A2 half, mask slots 64 up, rest ones
  function automatic logic [71:0] ref_tree(logic [63:0] dq, logic [7:0] dmn, int ln, logic dmu);
    logic [71:0] t;
    t = '1;
    for (int b = 0; b < 4; b++) begin
      for (int p = 0; p < 8; p++) begin
        t[p*8+b] = dq[b*16+ln*8+p];
      end
      if (dmu) begin
        t[64+b] = dmn[b*2+ln];
      end
    end
    return t;
  endfunction : ref_tree

  function automatic logic [7:0] ref_crc(logic [71:0] t);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : ref_crc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask : wr

  task automatic mrs(input logic [2:0] a, input logic [12:0] d);
    wr(wcca_pkg::REG_MRS, {3'h0, d, 13'h0000, a});
  endtask : mrs

  task automatic burst(input logic [63:0] dq, input logic [7:0] dmn, input logic a2, input logic [1:0] fl);
    wr(wcca_pkg::REG_WDATA0, dq[31:0]);
    wr(wcca_pkg::REG_WDATA1, dq[63:32]);
    wr(wcca_pkg::REG_WCTRL, {1'b1, fl, 20'h00000, a2, dmn});
    repeat (80) @(posedge clock);
  endtask : burst

  task automatic good(input logic [63:0] dq, input logic [7:0] dmn, input logic a2, input logic dmu);
    int w;
    int p;
    w = n_we;
    p = n_pl;
    burst(dq, dmn, a2, 2'b00);
    chk("crc lane0", 64'(ref_crc(ref_tree(dq, dmn, 0, dmu))), 64'(cap_crc[7:0]));
    chk("crc lane1", 64'(ref_crc(ref_tree(dq, dmn, 1, dmu))), 64'(cap_crc[15:8]));
    chk("crc0 equation", 64'(^(ref_tree(dq, dmn, 0, dmu) & CRC0_TERMS)), 64'(cap_crc[0]));
    chk("commit", 64'(w + 1), 64'(n_we));
    chk("no alert", 64'(p), 64'(n_pl));
    chk("array data", dq, cap_arr);
    chk("array mask", 64'(dmu ? dmn : 8'hff), 64'(cap_dm));
  endtask : good

  task automatic bad(input logic [7:0] dmn, input logic rp, input int ewe);
    int w;
    int p;
    int v;
    w = n_we;
    p = n_pl;
    v = n_wv;
    burst(64'h5555_aaaa_0f0f_f0f0, dmn, 1'b0, {1'b1, rp});
    chk("commit count", 64'(w + ewe), 64'(n_we));
    chk("sends", 64'(v + 1 + int'(rp)), 64'(n_wv));
    chk("alert pulses", 64'(p + 1), 64'(n_pl));
    chk("alert width", 64'(wcca_pkg::CRC_ALERT_CYC), 64'(last_low));
    chk("error bit", 64'(1), 64'(lk.err_status));
    chk("error log", 64'(1), 64'(lk.err_log));
  endtask : bad

  task automatic t_regs;
    logic [31:0] rd;
    logic        e;
    apb(1'b0, wcca_pkg::REG_STATUS, 32'h0, rd, e);
    chk("status at reset", 64'h0, 64'(rd[25:0]));
    apb(1'b0, 8'h14, 32'h0, rd, e);
    chk("unmapped error", 64'(1), 64'(e));
    chk("unmapped data", 64'h0, 64'(rd));
    apb(1'b0, wcca_pkg::REG_WCTRL, 32'h0, rd, e);
    chk("control reads zero", 64'h0, 64'(rd));
  endtask : t_regs

  task automatic t_clean;
    mrs(wcca_pkg::MR2_ADDR, 13'h1000);
    good(64'h0123_4567_89ab_cdef, 8'hff, 1'b0, 1'b0);
    good(64'h0123_4567_89ab_cdef, 8'h00, 1'b1, 1'b0);
    x16_en <= 1'b0;
    good(64'hc3c3_0000_ffff_1234, 8'hff, 1'b1, 1'b0);
    x16_en <= 1'b1;
  endtask : t_clean

  task automatic t_mask;
    logic [31:0] rd;
    logic        e;
    mrs(wcca_pkg::MR5_ADDR, 13'h0400);
    good(64'hfedc_ba98_7654_3210, 8'h5a, 1'b1, 1'b1);
    good(64'h8421_1248_0ff0_a55a, 8'ha5, 1'b0, 1'b1);
    bad(8'h3c, 1'b0, 0);
    good(64'h1111_2222_3333_4444, 8'hff, 1'b0, 1'b1);
    chk("flag kept", 64'(1), 64'(lk.err_log));
    apb(1'b0, wcca_pkg::REG_STATUS, 32'h0, rd, e);
    chk("crc class count", 64'(1), 64'(rd[15:8]));
    mrs(wcca_pkg::MR5_ADDR, 13'h0400);
    repeat (4) @(posedge clock);
    chk("status cleared", 64'h0, 64'(lk.err_status));
    chk("log cleared", 64'h0, 64'(lk.err_log));
  endtask : t_mask

  task automatic t_nomask;
    logic [31:0] rd;
    logic        e;
    mrs(wcca_pkg::MR5_ADDR, 13'h0000);
    bad(8'h00, 1'b1, 2);
    apb(1'b0, wcca_pkg::REG_STATUS, 32'h0, rd, e);
    chk("crc class count", 64'(2), 64'(rd[15:8]));
    mrs(wcca_pkg::MR5_ADDR, 13'h0000);
  endtask : t_nomask

  task automatic t_parity;
    logic [31:0] rd;
    logic        e;
    @(posedge clock);
    ca_parity_err <= 1'b1;
    @(posedge clock);
    ca_parity_err <= 1'b0;
    repeat (80) @(posedge clock);
    chk("parity width", 64'(wcca_pkg::PARITY_ALERT_CYC), 64'(last_low));
    chk("no crc flag", 64'h0, 64'(lk.err_status));
    apb(1'b0, wcca_pkg::REG_STATUS, 32'h0, rd, e);
    chk("parity class count", 64'(1), 64'(rd[23:16]));
  endtask : t_parity

  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_clean();
    t_mask();
    t_nomask();
    t_parity();
    stop_test();
  end

  initial begin
    repeat (8000) @(posedge clock);
    n_mismatch++;
    stop_test();
  end
endmodule : test_write_crc_check_and_alert
`default_nettype wire
